// >>> shared/ccx_pkg.sv
// shared constants for the clear / complement / indirect call executor
package ccx_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADR_INSTR = 8'h00;
	localparam logic [7:0] ADR_CTRL = 8'h04;
	localparam logic [7:0] ADR_ACCUM = 8'h08;
	localparam logic [7:0] ADR_BANK = 8'h0c;
	localparam logic [7:0] ADR_PCHI = 8'h10;
	localparam logic [7:0] ADR_PCUP = 8'h14;
	localparam logic [7:0] ADR_STATUS = 8'h18;
	localparam logic [7:0] ADR_PC = 8'h1c;
	localparam logic [7:0] ADR_STACK = 8'h20;
	localparam logic [7:0] ADR_WDOG = 8'h24;
	localparam logic [7:0] ADR_INDEX = 8'h28;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_EXT_BIT = 0;
	localparam int ST_C_BIT = 0;
	localparam int ST_DC_BIT = 1;
	localparam int ST_Z_BIT = 2;
	localparam int ST_OV_BIT = 3;
	localparam int ST_N_BIT = 4;
	localparam int ST_SLEEP_BIT = 5;
	localparam int ST_TIMEOUT_BIT = 6;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] STATUS_RST = 8'h60;
	localparam logic [20:0] PC_RST = 21'h000000;
	// ----------------------------------------
	// encodings and addressing
	// ----------------------------------------
	localparam logic [15:0] OPC_CALL_ACC = 16'h0014;
	localparam logic [15:0] OPC_WDOG_CLR = 16'h0004;
	localparam logic [6:0] OPC_CLEAR_HI = 7'h35;
	localparam logic [5:0] OPC_INVERT_HI = 6'h07;
	localparam logic [20:0] PC_STEP = 21'h000002;
	localparam logic [7:0] LIT_OFS_MAX = 8'h5f;
	localparam logic [7:0] ACC_SPLIT = 8'h60;
	localparam logic [3:0] ACC_HI_BANK = 4'hf;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int INSTR_CYCLE_NS = 80;
	localparam int Q_PHASES = INSTR_CYCLE_NS / CLK_PERIOD_NS;
	// ----------------------------------------
	// phase sequencer
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_Q1 = 5'b00010,
		ST_Q2 = 5'b00100,
		ST_Q3 = 5'b01000,
		ST_Q4 = 5'b10000
	} ccx_state_t;
endpackage

// >>> hdl/ccx_exec.sv
// executor for indirect call, clear, watchdog clear and invert instructions
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - indirect call pushes own address plus 2
// - pc gets accumulator, high latch, upper latch
// - indirect call takes two cycles, second idle
// - clear_reg_op writes zero to selected register
// - clear_reg_op sets zero flag only
// - access bit picks access bank or bank_select
// - extended set, a=0, f<=95: indexed offset
// - watchdog_clear_op sets timeout and sleep flags
// - invert_reg_op inverts, updates negative and zero
// - destination bit picks accumulator or register
module ccx_exec
	import ccx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic [11:0] dmem_addr_o,
	output logic dmem_re_o,
	output logic dmem_we_o,
	output logic [7:0] dmem_wdata_o,
	input wire logic [7:0] dmem_rdata_i,
	output logic busy_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	ccx_state_t state_q;
	logic cyc2_q;
	logic [15:0] instr_q;
	logic ext_en_q;
	logic [7:0] accum_q;
	logic [7:0] bank_q;
	logic [7:0] pchi_q;
	logic [7:0] pcup_q;
	logic [7:0] status_q;
	logic [20:0] pc_q;
	logic [20:0] stack_q;
	logic [15:0] wdog_q;
	logic [11:0] index_q;
	logic [7:0] opnd_q;
	logic ack_q;
	logic [31:0] rdat_q;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic bus_req;
	logic bus_wr;
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];

	// ----------------------------------------
	// instruction decode
	// ----------------------------------------
	logic is_call;
	logic is_wclr;
	logic is_clear;
	logic is_invert;
	logic acc_bit;
	logic dst_bit;
	logic [7:0] fld;
	logic [11:0] ea;
	logic [7:0] inv_res;
	logic first_q4;
	logic first_q3;

	assign is_call = instr_q == OPC_CALL_ACC;
	assign is_wclr = instr_q == OPC_WDOG_CLR;
	assign is_clear = instr_q[15:9] == OPC_CLEAR_HI;
	assign is_invert = instr_q[15:10] == OPC_INVERT_HI;
	assign acc_bit = instr_q[8];
	assign dst_bit = instr_q[9];
	assign fld = instr_q[7:0];
	assign inv_res = ~opnd_q;
	assign first_q4 = (state_q == ST_Q4) & ~cyc2_q;
	assign first_q3 = (state_q == ST_Q3) & ~cyc2_q;

	// effective data address
	always_comb begin
		if (acc_bit) begin
			ea = {bank_q[3:0], fld};
		end else if (ext_en_q && fld <= LIT_OFS_MAX) begin
			// offset adds to the index base; wraps in 12 bits
			ea = index_q + {4'h0, fld};
		end else if (fld < ACC_SPLIT) begin
			ea = {4'h0, fld};
		end else begin
			ea = {ACC_HI_BANK, fld};
		end
	end

	// ----------------------------------------
	// phase sequencer
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			cyc2_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (bus_wr && wb_adr_i == ADR_INSTR) begin
						state_q <= ST_Q1;
					end
					cyc2_q <= 1'b0;
				end
				ST_Q1: begin
					state_q <= ST_Q2;
				end
				ST_Q2: begin
					state_q <= ST_Q3;
				end
				ST_Q3: begin
					state_q <= ST_Q4;
				end
				ST_Q4: begin
					if (is_call && !cyc2_q) begin
						// idle second cycle while target fetch happens
						state_q <= ST_Q1;
						cyc2_q <= 1'b1;
					end else begin
						state_q <= ST_IDLE;
						cyc2_q <= 1'b0;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					cyc2_q <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			busy_o <= bus_wr && wb_adr_i == ADR_INSTR;
		end else begin
			busy_o <= !(state_q == ST_Q4 && !(is_call && !cyc2_q));
		end
	end

	// instruction word, only taken while idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			instr_q <= 16'h0000;
		end else if (state_q == ST_IDLE && bus_wr && wb_adr_i == ADR_INSTR) begin
			instr_q <= wb_dat_i[15:0];
		end
	end

	// ----------------------------------------
	// data memory side
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dmem_addr_o <= 12'h000;
			dmem_re_o <= 1'b0;
		end else begin
			dmem_re_o <= 1'b0;
			if (state_q == ST_Q1 && !cyc2_q && (is_clear || is_invert)) begin
				dmem_addr_o <= ea;
				dmem_re_o <= 1'b1;
			end
		end
	end

	// read data arrives the cycle after the read strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opnd_q <= 8'h00;
		end else if (first_q3) begin
			opnd_q <= dmem_rdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dmem_we_o <= 1'b0;
			dmem_wdata_o <= 8'h00;
		end else begin
			dmem_we_o <= 1'b0;
			if (first_q4 && is_clear) begin
				dmem_we_o <= 1'b1;
				dmem_wdata_o <= 8'h00;
			end else if (first_q4 && is_invert && dst_bit) begin
				dmem_we_o <= 1'b1;
				dmem_wdata_o <= inv_res;
			end
		end
	end

	// ----------------------------------------
	// core registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			accum_q <= 8'h00;
		end else if (first_q4 && is_invert && !dst_bit) begin
			accum_q <= inv_res;
		end else if (bus_wr && wb_adr_i == ADR_ACCUM) begin
			accum_q <= wb_dat_i[7:0];
		end
	end

	// flag updates win over a software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= STATUS_RST;
		end else if (first_q4 && is_clear) begin
			status_q[ST_Z_BIT] <= 1'b1;
		end else if (first_q4 && is_invert) begin
			status_q[ST_N_BIT] <= inv_res[7];
			status_q[ST_Z_BIT] <= inv_res == 8'h00;
		end else if (first_q4 && is_wclr) begin
			status_q[ST_TIMEOUT_BIT] <= 1'b1;
			status_q[ST_SLEEP_BIT] <= 1'b1;
		end else if (bus_wr && wb_adr_i == ADR_STATUS) begin
			status_q <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stack_q <= 21'h000000;
		end else if (first_q3 && is_call) begin
			stack_q <= pc_q + PC_STEP;
		end else if (bus_wr && wb_adr_i == ADR_STACK) begin
			stack_q <= wb_dat_i[20:0];
		end
	end

	// redirect lands in the first Q4, one cycle after the push in the first Q3
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_q <= PC_RST;
		end else if (first_q4 && is_call) begin
			pc_q <= {pcup_q[4:0], pchi_q, accum_q};
		end else if (first_q4) begin
			pc_q <= pc_q + PC_STEP;
		end else if (bus_wr && wb_adr_i == ADR_PC && state_q == ST_IDLE) begin
			pc_q <= wb_dat_i[20:0];
		end
	end

	// free-running; no timeout action here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdog_q <= 16'h0000;
		end else if (first_q4 && is_wclr) begin
			wdog_q <= 16'h0000;
		end else begin
			wdog_q <= wdog_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_en_q <= 1'b0;
			bank_q <= 8'h00;
			pchi_q <= 8'h00;
			pcup_q <= 8'h00;
			index_q <= 12'h000;
		end else if (bus_wr) begin
			case (wb_adr_i)
				ADR_CTRL: ext_en_q <= wb_dat_i[CTRL_EXT_BIT];
				ADR_BANK: bank_q <= wb_dat_i[7:0];
				ADR_PCHI: pchi_q <= wb_dat_i[7:0];
				ADR_PCUP: pcup_q <= wb_dat_i[7:0];
				ADR_INDEX: index_q <= wb_dat_i[11:0];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req;
		end
	end

	assign wb_ack_o = ack_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 32'h00000000;
		end else if (bus_req) begin
			case (wb_adr_i)
				ADR_INSTR: rdat_q <= {16'h0000, instr_q};
				ADR_CTRL: rdat_q <= {31'h00000000, ext_en_q};
				ADR_ACCUM: rdat_q <= {24'h000000, accum_q};
				ADR_BANK: rdat_q <= {24'h000000, bank_q};
				ADR_PCHI: rdat_q <= {24'h000000, pchi_q};
				ADR_PCUP: rdat_q <= {24'h000000, pcup_q};
				ADR_STATUS: rdat_q <= {24'h000000, status_q};
				ADR_PC: rdat_q <= {11'h000, pc_q};
				ADR_STACK: rdat_q <= {11'h000, stack_q};
				ADR_WDOG: rdat_q <= {16'h0000, wdog_q};
				ADR_INDEX: rdat_q <= {20'h00000, index_q};
				// unmapped addresses read as zero
				default: rdat_q <= 32'h00000000;
			endcase
		end
	end

	assign wb_dat_o = rdat_q;

endmodule

`default_nettype wire

// >>> verif/ccx_mem_model.sv
// data memory model with a one-cycle synchronous read
`timescale 1ns/1ps
`default_nettype none
module ccx_mem_model (
	input wire logic clk_i,
	input wire logic [11:0] addr_i,
	input wire logic re_i,
	input wire logic we_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o = 8'h5a
);
	logic [7:0] mem [4096];
	always @(posedge clk_i) begin
		// outside a read the line toggles, so stale data never looks valid
		if (re_i) rdata_o <= mem[addr_i];
		else rdata_o <= ~rdata_o;
		if (we_i) mem[addr_i] <= wdata_i;
	end
endmodule
`default_nettype wire

// >>> verif/ccx_exec_monitor.sv
// concurrent checks on the executor ports
`timescale 1ns/1ps
`default_nettype none
module ccx_exec_monitor
	import ccx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [11:0] dmem_addr_o,
	input wire logic dmem_re_o,
	input wire logic dmem_we_o,
	input wire logic [7:0] dmem_wdata_o,
	input wire logic [7:0] dmem_rdata_i,
	input wire logic busy_o
);
	logic [15:0] ins_q;
	logic [7:0] rd_q;
	logic re_q;
	logic take;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == ADR_INSTR && !busy_o;
	// remembers the running opcode and the operand it read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ins_q <= 16'h0000;
			re_q <= 1'b0;
			rd_q <= 8'h00;
		end else begin
			re_q <= dmem_re_o;
			if (take) ins_q <= wb_dat_i[15:0];
			if (re_q) rd_q <= dmem_rdata_i;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	start_busy_a: assert property (take |=> busy_o) else $error("no start");
	call_len_a: assert property ($rose(busy_o) && ins_q == OPC_CALL_ACC |->
		busy_o [*8] ##1 !busy_o) else $error("call length");
	short_len_a: assert property ($rose(busy_o) && ins_q != OPC_CALL_ACC |->
		busy_o [*4] ##1 !busy_o) else $error("instr length");
	clear_zero_a: assert property (dmem_we_o && ins_q[15:9] == OPC_CLEAR_HI |->
		dmem_wdata_o == 8'h00) else $error("clear data");
	invert_data_a: assert property (dmem_we_o && ins_q[15:10] == OPC_INVERT_HI |->
		dmem_wdata_o == ~rd_q) else $error("invert data");
	dest_sel_a: assert property (dmem_we_o |-> ins_q[15:9] == OPC_CLEAR_HI
		|| ins_q[15:9] == {OPC_INVERT_HI, 1'b1}) else $error("bad write");
	bank_addr_a: assert property (dmem_re_o && ins_q[8] |->
		dmem_addr_o[7:0] == ins_q[7:0]) else $error("bank address");
endmodule
bind ccx_exec ccx_exec_monitor u_mon (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_we_i,
	.wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .dmem_addr_o, .dmem_re_o, .dmem_we_o,
	.dmem_wdata_o, .dmem_rdata_i, .busy_o);
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the executor
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ccx_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic [7:0] adr = 8'h00, rdata, wdata;
	logic [31:0] dat = 32'h0, dat_o, q, p, st;
	logic [31:0] seed = 32'h755c3945;
	logic [11:0] addr;
	logic ack, re, wr, busy;
	int failures = 0, num_checks = 0, cycles = 0;
	ccx_exec u_dut (.clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
		.dmem_addr_o(addr), .dmem_re_o(re), .dmem_we_o(wr), .dmem_wdata_o(wdata),
		.dmem_rdata_i(rdata), .busy_o(busy));
	ccx_mem_model u_mem (.clk_i, .addr_i(addr), .re_i(re), .we_i(wr), .wdata_i(wdata),
		.rdata_o(rdata));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [11:0] eaddr(input logic a, input logic [7:0] f,
		input logic ext, input logic [3:0] bk, input logic [11:0] base);
		if (a) return {bk, f};
		if (ext && f <= 8'h5f) return base + {4'h0, f};
		return (f < 8'h60) ? {4'h0, f} : {4'hf, f};
	endfunction
	function automatic logic [31:0] exp_st(input logic [31:0] s, input logic clr,
		input logic [7:0] r);
		s[ST_Z_BIT] = clr || r == 8'h00;
		if (!clr) s[ST_N_BIT] = r[7];
		return s;
	endfunction
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic run(input logic [15:0] op);
		wb(1'b1, ADR_INSTR, {16'h0, op});
		do @(posedge clk_i); while (busy !== 1'b0);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// hang guard, far above the fewer than a thousand cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		logic [7:0] f, v, ac, bk;
		logic [11:0] base, ea;
		logic ext, a;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, ADR_STATUS, 0);
		chk(q, {24'h0, STATUS_RST});
		wb(1'b0, 8'h3c, 0);
		chk(q, 0);
		// first six hit the access-bank split and literal offset edges
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			f = (i < 6) ? (i[0] ? 8'h60 : 8'h5f) : seed[7:0];
			v = (i == 7) ? 8'hff : seed[15:8];
			ac = seed[23:16];
			bk = {4'h0, seed[27:24]};
			ext = (i < 6) ? i[1] : seed[28];
			a = (i < 6) ? 1'b0 : seed[29];
			base = seed[31:20];
			st = {25'h0, seed[6:0]};
			wb(1'b1, ADR_CTRL, {31'h0, ext});
			wb(1'b1, ADR_BANK, {24'h0, bk});
			wb(1'b1, ADR_INDEX, {20'h0, base});
			wb(1'b1, ADR_ACCUM, {24'h0, ac});
			wb(1'b1, ADR_STATUS, st);
			ea = eaddr(a, f, ext, bk[3:0], base);
			u_mem.mem[ea] = v;
			case (i % 3)
				0: run({7'h35, a, f});
				1: run({6'h07, 1'b1, a, f});
				default: run({6'h07, 1'b0, a, f});
			endcase
			wb(1'b0, ADR_ACCUM, 0);
			chk(q, {24'h0, (i % 3 == 2) ? ~v : ac});
			chk({24'h0, u_mem.mem[ea]}, {24'h0, (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? ~v : v});
			wb(1'b0, ADR_STATUS, 0);
			chk(q, exp_st(st, i % 3 == 0, ~v));
		end
		wb(1'b1, ADR_STATUS, 32'h1f);
		run(OPC_WDOG_CLR);
		wb(1'b0, ADR_WDOG, 0);
		chk({31'h0, q < 32'h8}, 1);
		wb(1'b0, ADR_STATUS, 0);
		chk(q, 32'h7f);
		for (int j = 0; j < 2; j++) begin
			seed = lfsr(seed);
			ac = j ? seed[7:0] : 8'h06;
			bk = j ? seed[15:8] : 8'h10;
			f = j ? {3'h0, seed[20:16]} : 8'h00;
			wb(1'b1, ADR_ACCUM, {24'h0, ac});
			wb(1'b1, ADR_PCHI, {24'h0, bk});
			wb(1'b1, ADR_PCUP, {24'h0, f});
			wb(1'b0, ADR_PC, 0);
			p = q;
			wb(1'b0, ADR_STATUS, 0);
			st = q;
			// the second instruction lands while busy and must be dropped
			wb(1'b1, ADR_INSTR, {16'h0, OPC_CALL_ACC});
			run(OPC_WDOG_CLR);
			wb(1'b0, ADR_PC, 0);
			chk(q, {11'h0, f[4:0], bk, ac});
			wb(1'b0, ADR_STACK, 0);
			chk(q, p + 32'h2);
			wb(1'b0, ADR_STATUS, 0);
			chk(q, st);
		end
		finish_test();
	end
endmodule
`default_nettype wire
